// *** scb_pkg.sv ***
// Purpose: shared constants and carriers for the serial clock/rx buffer block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, aligned words
// Notes:   delay is counted in units of 0.0001 ms (100 ns)
package scb_pkg;
  // register byte offsets
  localparam logic [5:0] A_CTRL  = 6'h00;
  localparam logic [5:0] A_DLY   = 6'h04;
  localparam logic [5:0] A_RATE  = 6'h08;
  localparam logic [5:0] A_SIZE  = 6'h0C;
  localparam logic [5:0] A_BSTAT = 6'h10;
  localparam logic [5:0] A_CMD   = 6'h14;
  localparam logic [5:0] A_SIG   = 6'h18;
  localparam logic [5:0] A_IST   = 6'h1C;
  localparam logic [5:0] A_ICLR  = 6'h20;
  localparam logic [5:0] A_IEN   = 6'h24;
  // reset values: 2.0000 ms at 4.096 Mbit/s gives 8192 bits
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [23:0] DLY_RST  = 24'h004E20;
  localparam logic [31:0] RATE_RST = 32'h003E8000;
  localparam logic [23:0] DLY_MIN  = 24'h000001;
  localparam logic [23:0] DLY_MAX  = 24'h98967F;
  localparam logic [55:0] UNITS    = 56'h0000000098_9680;
  // buffer geometry in bits
  localparam int          PTR_W  = 14;
  localparam int          DEPTH  = 16384;
  localparam logic [14:0] SZ_MIN = 15'h0002;
  localparam logic [14:0] SZ_MAX = 15'h4000;
  // internal clock divider, cycles of mclk per bit
  localparam logic [7:0]  INT_DIV = 8'h10;
  localparam logic [7:0]  INT_HALF = 8'h08;
  // clock source codes
  localparam logic [1:0] TX_INT = 2'h0;
  localparam logic [1:0] TX_TT  = 2'h1;
  localparam logic [1:0] TX_RX  = 2'h2;
  localparam logic [1:0] RX_DMD = 2'h0;
  localparam logic [1:0] RX_INT = 2'h1;
  localparam logic [1:0] RX_MOD = 2'h2;
  localparam logic [1:0] RX_TT  = 2'h3;
  // command entry values
  localparam logic [31:0] CMD_CLR = 32'h00000000;
  localparam logic [31:0] CMD_CTR = 32'h00000001;
  localparam logic [7:0]  PCT_MID = 8'h64;
  // interrupt bits
  localparam int IB_SLIP = 0;
  localparam int IB_SIG  = 1;
  localparam int IRQ_W   = 2;
  // control register layout, lsb = tx_src
  typedef struct packed {
    logic       svc_en;
    logic       rxd_inv;
    logic       rxc_inv;
    logic [1:0] rx_src;
    logic       tx_inv;
    logic [1:0] tx_src;
  } scb_cfg_s;
  // handshake and service channel line states
  typedef struct packed {
    logic ta;
    logic ca;
    logic rts;
    logic cts;
    logic dcd;
    logic dtr;
    logic dsr;
  } scb_sig_s;
  // every pin input that crosses into mclk
  typedef struct packed {
    logic     tt_clk;
    logic     dmd_clk;
    logic     mod_clk;
    logic     dmd_data;
    logic     send_data;
    scb_sig_s sig;
  } scb_pin_s;
endpackage

// *** scb_top.sv ***
// Purpose: clock select, polarity and elastic receive buffer of the
//          high speed serial data interface
// Assumes: all pins are asynchronous to mclk and run well below mclk/4
// Notes:   registers over Avalon-MM, one wait state on every access
// Overview of operation
// RULE_01: transmit data is clocked by internal (0), terminal timing (1) or receive clock (2).
// RULE_02: transmit data, receive clock and receive data each have a pass (0) or invert (1) setting.
// RULE_03: receive clock comes from demod (0), internal, modulator or terminal timing (3), demod bypassing the buffer.
// RULE_04: buffer depth is set as a delay of 0.0001 to 999.9999 ms, limited by the receive data rate.
// RULE_05: the buffer size in bits, from delay and rate, is readable.
// RULE_06: writing 1 to the command re-centres the buffer to its midpoint.
// RULE_07: writing 0 to the command clears the slip count without re-centring.
// RULE_08: fill is reported as a percentage with 100 at centre, only while the buffer is in use.
// RULE_09: the TA and CA line states are reported one bit each.
// RULE_10: service channel RTS, CTS, DCD, DTR and DSR are reported only while enabled.
// RULE_11: an overflow or underflow counts a slip and re-centres the buffer.
// RULE_12: with terminal timing selected the terminal supplies a steady clock and aligned data.
`timescale 1ns/1ns
module scb_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register bus
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // terminal side
  input  wire logic        tt_clk,
  input  wire logic        send_data,
  output logic             rcv_clk,
  output logic             rcv_data,
  // modem side
  input  wire logic        dmd_clk,
  input  wire logic        dmd_data,
  input  wire logic        mod_clk,
  output logic             mod_data,
  // handshake and service channel lines
  input  wire logic        ta,
  input  wire logic        ca,
  input  wire logic        svc_rts,
  input  wire logic        svc_cts,
  input  wire logic        svc_dcd,
  input  wire logic        svc_dtr,
  input  wire logic        svc_dsr,
  // interrupt
  output logic             irq
);
  scb_pkg::scb_pin_s pins, s1_r, s2_r, s3_r, rise;
  scb_pkg::scb_cfg_s cfg_r;
  scb_pkg::scb_sig_s sig_now, sig_r;
  logic [23:0]  dly_r;
  logic [31:0]  rate_r;
  logic [14:0]  size_r, fill_r;
  logic [scb_pkg::PTR_W-1:0] wr_ptr_r, rd_ptr_r, half;
  logic [15:0]  slip_cnt_r;
  logic [7:0]   pct_r, div_r;
  logic [scb_pkg::IRQ_W-1:0] ist_r, ien_r, iev;
  logic [31:0]  rdata;
  logic         ack_r, wr_en, int_tick, int_lvl, rx_lvl, rx_tick, tx_tick;
  logic         buf_on, buf_on_r, wr_tick, rd_tick, ovf, unf, slip;
  logic         cmd_ctr, cmd_clr, recenter;
  logic         mem [scb_pkg::DEPTH];

  // bits of buffer for a delay in 100 ns units at a rate in bit/s
  function automatic logic [14:0] calc_size(logic [23:0] d, logic [31:0] r);
    logic [55:0] q;
    q = (56'(d) * 56'(r)) / scb_pkg::UNITS;
    if (q < 56'(scb_pkg::SZ_MIN)) q = 56'(scb_pkg::SZ_MIN);
    if (q > 56'(scb_pkg::SZ_MAX)) q = 56'(scb_pkg::SZ_MAX);
    return 15'(q) & ~15'h0001; // even, so the midpoint is exact
  endfunction

  // fill as percent of half the buffer
  function automatic logic [7:0] pct_of(logic [14:0] f, logic [14:0] s);
    logic [22:0] n;
    n = 23'(f) * 23'h0000C8;
    return 8'(n / 23'(s));
  endfunction

  // pin synchroniser; edges are found on the second and third stage
  assign pins = {tt_clk, dmd_clk, mod_clk, dmd_data, send_data,
                 ta, ca, svc_rts, svc_cts, svc_dcd, svc_dtr, svc_dsr};
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r;

  // internal bit clock as an enable pulse from a divider
  always_ff @(posedge mclk) begin
    if (rst || int_tick) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end
  assign int_tick = (div_r == scb_pkg::INT_DIV - 8'h01);
  assign int_lvl  = (div_r < scb_pkg::INT_HALF);

  // receive clock source; the demod choice skips the buffer
  always_comb begin
    rx_lvl  = s2_r.dmd_clk;
    rx_tick = rise.dmd_clk;
    unique case (cfg_r.rx_src) // see RULE_03
      scb_pkg::RX_DMD: begin
        rx_lvl  = s2_r.dmd_clk;
        rx_tick = rise.dmd_clk;
      end
      scb_pkg::RX_INT: begin
        rx_lvl  = int_lvl;
        rx_tick = int_tick;
      end
      scb_pkg::RX_MOD: begin
        rx_lvl  = s2_r.mod_clk;
        rx_tick = rise.mod_clk;
      end
      scb_pkg::RX_TT: begin
        rx_lvl  = s2_r.tt_clk;
        rx_tick = rise.tt_clk;
      end
    endcase
  end
  assign buf_on = (cfg_r.rx_src != scb_pkg::RX_DMD); // see RULE_03

  // transmit clock source; code 3 falls back to internal
  always_comb begin
    unique case (cfg_r.tx_src) // see RULE_01
      scb_pkg::TX_TT: tx_tick = rise.tt_clk; // see RULE_12
      scb_pkg::TX_RX: tx_tick = rx_tick;
      default:        tx_tick = int_tick;
    endcase
  end

  // transmit data toward the modulator
  always_ff @(posedge mclk) begin
    if (rst) mod_data <= 1'b0;
    else if (tx_tick) mod_data <= cfg_r.tx_inv ^ s2_r.send_data; // see RULE_02
  end

  // avalon slave: one wait state, read data captured in the first cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_en = avs_write & ack_r;
  always_ff @(posedge mclk) begin
    if (rst) ack_r <= 1'b0;
    else ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // command decode, a write that lands on the command word
  assign cmd_ctr = wr_en && avs_address == scb_pkg::A_CMD
                   && avs_writedata == scb_pkg::CMD_CTR; // see RULE_06
  assign cmd_clr = wr_en && avs_address == scb_pkg::A_CMD
                   && avs_writedata == scb_pkg::CMD_CLR; // see RULE_07

  // configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r  <= scb_pkg::CTRL_RST;
      dly_r  <= scb_pkg::DLY_RST;
      rate_r <= scb_pkg::RATE_RST;
      ien_r  <= '0;
    end else if (wr_en) begin
      unique case (avs_address)
        scb_pkg::A_CTRL: cfg_r  <= avs_writedata[7:0];
        scb_pkg::A_RATE: rate_r <= avs_writedata;
        scb_pkg::A_IEN:  ien_r  <= avs_writedata[scb_pkg::IRQ_W-1:0];
        scb_pkg::A_DLY: begin // see RULE_04
          if (avs_writedata[23:0] < scb_pkg::DLY_MIN) dly_r <= scb_pkg::DLY_MIN;
          else if (avs_writedata[23:0] > scb_pkg::DLY_MAX ||
                   |avs_writedata[31:24]) dly_r <= scb_pkg::DLY_MAX;
          else dly_r <= avs_writedata[23:0];
        end
        default: ;
      endcase
    end
  end

  // size follows delay and rate, clamped to what the memory holds
  always_ff @(posedge mclk) begin
    if (rst) size_r <= calc_size(scb_pkg::DLY_RST, scb_pkg::RATE_RST);
    else size_r <= calc_size(dly_r, rate_r); // see RULE_04 RULE_05
  end

  // elastic buffer control
  assign wr_tick  = buf_on & rise.dmd_clk;
  assign rd_tick  = buf_on & rx_tick;
  assign ovf      = wr_tick & ~rd_tick & (fill_r >= size_r);
  assign unf      = rd_tick & ~wr_tick & (fill_r == 15'h0000);
  assign slip     = ovf | unf; // see RULE_11
  assign recenter = slip | cmd_ctr | (buf_on & ~buf_on_r);
  assign half     = size_r[14:1];

  // pointers and fill; a re-centre drops the bit moving that cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= '0;
      buf_on_r <= 1'b0;
    end else begin
      buf_on_r <= buf_on;
      if (recenter) begin // see RULE_06 RULE_11
        rd_ptr_r <= wr_ptr_r - half;
        fill_r   <= 15'(half);
      end else begin
        if (wr_tick) wr_ptr_r <= wr_ptr_r + 1'b1;
        if (rd_tick) rd_ptr_r <= rd_ptr_r + 1'b1;
        fill_r <= fill_r + 15'(wr_tick) - 15'(rd_tick);
      end
    end
  end

  // buffer storage, no reset so it maps onto ram
  always_ff @(posedge mclk) begin
    if (wr_tick && !recenter) mem[wr_ptr_r] <= s2_r.dmd_data;
  end

  // receive clock and data toward the terminal
  always_ff @(posedge mclk) begin
    if (rst) begin
      rcv_clk  <= 1'b0;
      rcv_data <= 1'b0;
    end else begin
      rcv_clk <= cfg_r.rxc_inv ^ rx_lvl; // see RULE_02
      if (!buf_on && rx_tick)
        rcv_data <= cfg_r.rxd_inv ^ s2_r.dmd_data; // see RULE_03
      else if (rd_tick && !recenter)
        rcv_data <= cfg_r.rxd_inv ^ mem[rd_ptr_r]; // see RULE_02
    end
  end

  // slip counter saturates; a slip in the clear cycle still counts
  always_ff @(posedge mclk) begin
    if (rst) slip_cnt_r <= 16'h0000;
    else if (cmd_clr) slip_cnt_r <= {15'h0000, slip}; // see RULE_07
    else if (slip && slip_cnt_r != 16'hFFFF)
      slip_cnt_r <= slip_cnt_r + 16'h0001; // see RULE_11
  end

  // fill percentage, zero while the buffer is bypassed
  always_ff @(posedge mclk) begin
    if (rst) pct_r <= 8'h00;
    else pct_r <= buf_on ? pct_of(fill_r, size_r) : 8'h00; // see RULE_08
  end

  // line states; service lines read as inactive while disabled
  always_comb begin
    sig_now = s2_r.sig; // see RULE_09
    if (!cfg_r.svc_en) begin // see RULE_10
      sig_now.rts = 1'b0;
      sig_now.cts = 1'b0;
      sig_now.dcd = 1'b0;
      sig_now.dtr = 1'b0;
      sig_now.dsr = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) sig_r <= '0;
    else sig_r <= sig_now;
  end

  // sticky interrupt status; a new event beats a clear
  always_comb begin
    iev = '0;
    iev[scb_pkg::IB_SLIP] = slip;
    iev[scb_pkg::IB_SIG]  = (sig_now != sig_r);
  end
  always_ff @(posedge mclk) begin
    if (rst) ist_r <= '0;
    else if (wr_en && avs_address == scb_pkg::A_ICLR)
      ist_r <= (ist_r & ~avs_writedata[scb_pkg::IRQ_W-1:0]) | iev;
    else ist_r <= ist_r | iev;
  end
  assign irq = |(ist_r & ien_r);

  // read mux; unmapped and write-only words read as zero
  always_comb begin
    rdata = 32'h00000000;
    case (avs_address)
      scb_pkg::A_CTRL:  rdata = 32'(cfg_r);
      scb_pkg::A_DLY:   rdata = 32'(dly_r);
      scb_pkg::A_RATE:  rdata = rate_r;
      scb_pkg::A_SIZE:  rdata = 32'(size_r); // see RULE_05
      scb_pkg::A_BSTAT: rdata = {7'h00, buf_on, pct_r, slip_cnt_r};
      scb_pkg::A_SIG:   rdata = 32'(sig_r);
      scb_pkg::A_IST:   rdata = 32'(ist_r);
      scb_pkg::A_IEN:   rdata = 32'(ien_r);
      default:          rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_r) avs_readdata <= rdata;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  tx_tt_data_a: assert property ( // see RULE_01
    cfg_r.tx_src == scb_pkg::TX_TT && rise.tt_clk |=>
    mod_data == ($past(cfg_r.tx_inv) ^ $past(s2_r.send_data)))
    else $error("tx data not taken on terminal clock");
  rx_clk_pol_a: assert property ( // see RULE_02
    ##1 rcv_clk == ($past(cfg_r.rxc_inv) ^ $past(rx_lvl)))
    else $error("rx clock polarity wrong");
  bypass_data_a: assert property ( // see RULE_03
    cfg_r.rx_src == scb_pkg::RX_DMD && rise.dmd_clk |=>
    rcv_data == ($past(cfg_r.rxd_inv) ^ $past(s2_r.dmd_data)))
    else $error("demod bypass data wrong");
  size_range_a: assert property ( // see RULE_04
    size_r >= scb_pkg::SZ_MIN && size_r <= scb_pkg::SZ_MAX && !size_r[0])
    else $error("buffer size out of range");
  size_read_a: assert property ( // see RULE_05
    avs_read && !ack_r && avs_address == scb_pkg::A_SIZE |=>
    avs_readdata == 32'($past(size_r)) && !avs_waitrequest)
    else $error("size readback wrong");
  recenter_a: assert property ( // see RULE_06
    cmd_ctr |=> fill_r == 15'($past(size_r) >> 1))
    else $error("re-centre did not reach midpoint");
  slip_clear_a: assert property ( // see RULE_07
    cmd_clr && !slip |=> slip_cnt_r == 16'h0000)
    else $error("slip clear failed");
  pct_mid_a: assert property ( // see RULE_08
    buf_on && fill_r == 15'(size_r >> 1) && $stable(size_r) |=>
    pct_r == scb_pkg::PCT_MID)
    else $error("centred buffer not 100 percent");
  pct_off_a: assert property ( // see RULE_08
    !buf_on |=> pct_r == 8'h00)
    else $error("fill shown while bypassed");
  ta_ca_rpt_a: assert property ( // see RULE_09
    1'b1 |=> sig_r.ta == $past(s2_r.sig.ta) && sig_r.ca == $past(s2_r.sig.ca))
    else $error("handshake status lags wrongly");
  svc_gate_a: assert property ( // see RULE_10
    !cfg_r.svc_en |=> sig_r[4:0] == 5'h00)
    else $error("service lines shown while disabled");
  slip_count_a: assert property ( // see RULE_11
    slip && !cmd_clr && slip_cnt_r != 16'hFFFF |=>
    slip_cnt_r == $past(slip_cnt_r) + 16'h0001
    && fill_r == 15'($past(size_r) >> 1))
    else $error("slip not counted or not re-centred");
endmodule

// *** scb_term.sv ***
// Purpose: terminal equipment model on the serial data pins
// Assumes: link clock period of 160 ns, phase free of mclk
// Notes:   clock parks low and data churns while run is low
`timescale 1ns/1ns
module scb_term (
  // control from the bench
  input  wire logic run,
  input  wire logic tx_bit,
  // pins toward the block
  output logic      tt_clk,
  output logic      send_data
);
  // steady clock while running, odd start so phase is unrelated
  initial begin
    tt_clk = 1'b0;
    #37;
    forever begin
      #80 tt_clk = run ? ~tt_clk : 1'b0;
    end
  end
  // launch on the fall so data is settled at the rising edge
  always @(negedge tt_clk) begin
    send_data <= tx_bit;
  end
  // no held value outside a run, so a wrong source shows up
  initial send_data = 1'b0;
  always #40 if (!run) send_data <= ~send_data;
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the serial clock/rx buffer block
// Assumes: one wait state per bus access, pins well below mclk/4
// Notes:   expected values queue up, monitors pop and compare them
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} scb_note_s;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, d, r;
  logic        tt_clk, send_data, rcv_clk, rcv_data, irq, ps, pv;
  logic        dmd_clk, dmd_data, mod_clk, mod_data, run, tx_bit;
  logic        ta, ca, svc_rts, svc_cts, svc_dcd, svc_dtr, svc_dsr;
  logic [6:0]  sl;
  logic [3:0]  v;
  scb_pkg::scb_cfg_s cfg;
  scb_note_s   q[$];
  int          fail_count, tests_run;
  integer      seed;

  scb_top dut (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .tt_clk,
    .send_data, .rcv_clk, .rcv_data, .dmd_clk, .dmd_data, .mod_clk,
    .mod_data, .ta, .ca, .svc_rts, .svc_cts, .svc_dcd, .svc_dtr,
    .svc_dsr, .irq);
  scb_term term (.run, .tx_bit, .tt_clk, .send_data);

  // 100 MHz system clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task stop_test;
    begin
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // pop the oldest note and compare under its mask
  task note(input logic [31:0] g);
    scb_note_s n;
    begin
      tests_run++;
      if (q.size() == 0) n = '{32'h0, 32'hFFFFFFFF};
      else n = q.pop_front();
      if (((g ^ n.e) & n.m) !== 32'h0) begin
        fail_count++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, n.e & n.m, g & n.m);
      end
    end
  endtask
  // read data is taken at the very edge where waitrequest is low
  always @(posedge mclk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) note(avs_readdata);
  always @(posedge mclk) if (ps) note({31'h0, pv});

  // one Avalon cycle, held until waitrequest is seen low
  // a hung slave is caught by the watchdog, not by this loop
  task bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    begin
      @(posedge mclk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= wd;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task setc;
    wr(scb_pkg::A_CTRL, {24'h0, cfg});
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // pin value is taken at a negedge, judged at the next rising edge
  task pin(input logic e, input logic g);
    q.push_back('{{31'h0, e}, 32'h1});
    pv <= g;
    ps <= 1'b1;
    @(posedge mclk);
    ps <= 1'b0;
  endtask
  // n rising edges on the demod (dm=1) or modulator clock pin
  task pls(input logic dm, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (dm) dmd_clk <= 1'b1;
      else mod_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      dmd_clk <= 1'b0;
      mod_clk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // reference size: bits = delay*rate/10^7, clamped and made even
  function automatic logic [31:0] bsz(input logic [63:0] dl, input logic [63:0] rt);
    logic [63:0] s;
    begin
      s = dl * rt / 64'd10000000;
      if (s < 64'd2) s = 64'd2;
      if (s > 64'd16384) s = 64'd16384;
      bsz = {s[31:1], 1'b0};
    end
  endfunction

  // watchdog sized well past the longest expected run
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {dmd_clk, dmd_data, mod_clk, ps, pv, run, tx_bit} = '0;
    {ta, ca, svc_rts, svc_cts, svc_dcd, svc_dtr, svc_dsr} = '0;
    cfg = '0;
    sl = '0;
    seed = 32'h0fe19ca4;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped and write-only words
    rd(scb_pkg::A_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(scb_pkg::A_DLY, {8'h0, scb_pkg::DLY_RST}, 32'hFFFFFFFF);
    rd(scb_pkg::A_RATE, scb_pkg::RATE_RST, 32'hFFFFFFFF);
    rd(scb_pkg::A_SIZE, 32'h2000, 32'hFFFFFFFF);
    rd(scb_pkg::A_BSTAT, 32'h0, 32'hFFFFFFFF);
    wr(6'h3C, 32'hFFFFFFFF);
    rd(6'h3C, 32'h0, 32'hFFFFFFFF);
    rd(scb_pkg::A_CMD, 32'h0, 32'hFFFFFFFF);
    $display("test reset_map done");
    // delay clamp at both ends, then random size products
    wr(scb_pkg::A_DLY, 32'h0);
    rd(scb_pkg::A_DLY, 32'h1, 32'hFFFFFFFF);
    wr(scb_pkg::A_DLY, 32'hFFFFFFFF);
    rd(scb_pkg::A_DLY, 32'h98967F, 32'hFFFFFFFF);
    repeat (4) begin
      d = ({$random(seed)} % 32'd50000) + 32'd1;
      r = {$random(seed)} % 32'd9000000;
      wr(scb_pkg::A_DLY, d);
      wr(scb_pkg::A_RATE, r);
      rd(scb_pkg::A_SIZE, bsz(d, r), 32'hFFFFFFFF);
    end
    $display("test size done");
    // line status with service channel off then on, change interrupt
    wr(scb_pkg::A_ICLR, 32'h3);
    wr(scb_pkg::A_IEN, 32'h2);
    for (int k = 0; k < 2; k++) begin
      cfg.svc_en = k[0];
      setc();
      sl = {~sl[6], 6'($random(seed))};
      {ta, ca, svc_rts, svc_cts, svc_dcd, svc_dtr, svc_dsr} <= sl;
      wt(6);
      rd(scb_pkg::A_SIG, {25'h0, k[0] ? sl : sl & 7'h60}, 32'hFF);
      rd(scb_pkg::A_IST, 32'h2, 32'h2);
      wt(1);
      pin(1'b1, irq);
      wr(scb_pkg::A_ICLR, 32'h2);
      wt(1);
      pin(1'b0, irq);
    end
    $display("test signaling done");
    // every transmit clock source with both polarities
    run <= 1'b1;
    cfg.rx_src = scb_pkg::RX_INT;
    for (int s = 0; s < 3; s++)
      for (int p = 0; p < 2; p++) begin
        tx_bit <= 1'($random(seed));
        cfg.tx_src = 2'(s);
        cfg.tx_inv = p[0];
        setc();
        wt(120);
        pin(tx_bit ^ p[0], mod_data);
      end
    // a stopped terminal clock must freeze transmit data
    tx_bit <= 1'b1;
    cfg.tx_src = scb_pkg::TX_TT;
    cfg.tx_inv = 1'b0;
    setc();
    wt(60);
    run <= 1'b0;
    wt(100);
    pin(1'b1, mod_data);
    $display("test transmit done");
    // demod bypass with each receive polarity pair
    cfg = '0;
    for (int k = 0; k < 4; k++) begin
      v = 4'(k);
      cfg.rxc_inv = v[0];
      cfg.rxd_inv = v[1];
      dmd_data <= 1'($random(seed));
      setc();
      pls(1'b1, 1);
      wt(4);
      pin(dmd_data ^ v[1], rcv_data);
      pin(v[0], rcv_clk);
      rd(scb_pkg::A_BSTAT, 32'h0, 32'h01FF0000);
    end
    $display("test bypass done");
    // 20-bit buffer clocked out by the modulator clock pin
    wr(scb_pkg::A_DLY, 32'd20);
    wr(scb_pkg::A_RATE, 32'd10000000);
    rd(scb_pkg::A_SIZE, 32'd20, 32'hFFFFFFFF);
    cfg.rx_src = scb_pkg::RX_MOD;
    setc();
    wr(scb_pkg::A_CMD, scb_pkg::CMD_CLR);
    wr(scb_pkg::A_ICLR, 32'h3);
    wr(scb_pkg::A_IEN, 32'h1);
    rd(scb_pkg::A_BSTAT, 32'h01640000, 32'h01FFFFFF);
    pls(1'b0, 10);
    rd(scb_pkg::A_BSTAT, 32'h01000000, 32'h01FFFFFF);
    wt(1);
    pin(1'b0, irq);
    pls(1'b0, 1);
    rd(scb_pkg::A_BSTAT, 32'h01640001, 32'h01FFFFFF);
    wt(1);
    pin(1'b1, irq);
    wr(scb_pkg::A_IEN, 32'h0);
    wt(1);
    pin(1'b0, irq);
    rd(scb_pkg::A_IST, 32'h1, 32'h1);
    wr(scb_pkg::A_ICLR, 32'h1);
    rd(scb_pkg::A_IST, 32'h0, 32'h1);
    pls(1'b1, 10);
    rd(scb_pkg::A_BSTAT, 32'h01C80001, 32'h01FFFFFF);
    pls(1'b1, 1);
    rd(scb_pkg::A_BSTAT, 32'h01640002, 32'h01FFFFFF);
    pls(1'b1, 5);
    wr(scb_pkg::A_CMD, scb_pkg::CMD_CLR);
    rd(scb_pkg::A_BSTAT, 32'h01960000, 32'h01FFFFFF);
    wr(scb_pkg::A_CMD, 32'h7);
    rd(scb_pkg::A_BSTAT, 32'h01960000, 32'h01FFFFFF);
    wr(scb_pkg::A_CMD, scb_pkg::CMD_CTR);
    rd(scb_pkg::A_BSTAT, 32'h01640000, 32'h01FFFFFF);
    $display("test buffer done");
    stop_test();
  end
endmodule
